// ===== rtl/vsdc_pkg.sv
// Behaviour
// - packet 27 code 0 sets page link flag
// - 525-line needs packet X/0/27/0 for link flag
// - detection flags stay set until software writes 0
// - packet 8/30 or 525-line 4/30 sets service flag
// - VPS line 16 field 0 stored row 25 block 9
// - line 16 decoded as teletext or VPS automatically
// - VPS byte: 4 data, error bit 4, zeros above
// - most significant VPS data bit stored as zero
// - VPS acquisition sets VPS received flag
// - capture all 14 wide screen bits on line 23
// - wide screen bits in three groups with error flags
// - wide screen capture only while enable set
// - wide screen acquisition sets received flag
// - caption capture on line 21 only while enabled
// - first caption byte first register, second second
// - caption registers cleared at selected line start
// - caption line end raises interrupt when enabled
// - 525-line magazine bits zero mean magazine 4
package vsdc_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_FLAGS     = 8'h04;
   localparam logic [7:0] OFS_WSS_A     = 8'h08;
   localparam logic [7:0] OFS_WSS_B     = 8'h0C;
   localparam logic [7:0] OFS_WSS_C     = 8'h10;
   localparam logic [7:0] OFS_CC_FIRST  = 8'h14;
   localparam logic [7:0] OFS_CC_SECOND = 8'h18;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h1C;
   localparam logic [7:0] OFS_IRQ_MASK  = 8'h20;
   localparam logic [7:0] OFS_VPS_BASE  = 8'h40;  // 16 words of vps row storage
   // control register fields
   localparam int CTRL_STD525_BIT  = 0;
   localparam int CTRL_VPS_EN_BIT  = 1;
   localparam int CTRL_WSS_EN_BIT  = 2;
   localparam int CTRL_CC_EN_BIT   = 3;
   localparam int CTRL_CC_IRQ_BIT  = 4;
   localparam int CTRL_CCLINE_LSB  = 8;
   localparam logic [4:0] CC_LINE_RST = 5'h15;   // line 21 after reset
   // flag register fields
   localparam int FLAG_LINK_BIT = 0;
   localparam int FLAG_SVC_BIT  = 1;
   localparam int FLAG_VPS_BIT  = 2;
   localparam int FLAG_WSS_BIT  = 3;
   localparam int FLAG_W        = 4;
   // interrupt status fields
   localparam int IRQ_CC_BIT  = 0;
   localparam int IRQ_VPS_BIT = 1;
   localparam int IRQ_WSS_BIT = 2;
   localparam int IRQ_W       = 3;
   // packet and line numbers
   localparam logic [4:0] PKT_LINK    = 5'h1B;    // packet 27
   localparam logic [4:0] PKT_SERVICE = 5'h1E;    // packet 30
   localparam logic [3:0] DESIG_ZERO  = 4'h0;
   localparam logic [8:0] LINE_VPS    = 9'h010;   // line 16
   localparam logic [8:0] LINE_WSS    = 9'h017;   // line 23
   localparam logic [3:0] VPS_MSB_IDX = 4'h0;     // byte holding the top data bit
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== rtl/vsdc_sticky.sv
module vsdc_sticky #(
   parameter int W = 4
) (
   input  wire logic         clk_sys,  // system clock
   input  wire logic         sys_rst,  // synchronous reset, active high
   input  wire logic [W-1:0] set_ev,   // hardware event pulses
   input  wire logic [W-1:0] clr_ev,   // software clear pulses
   output logic      [W-1:0] flag_q    // sticky flags
);
   // set has priority over a clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         flag_q <= '0;
      end else begin
         flag_q <= (flag_q & ~clr_ev) | set_ev;
      end
   end
endmodule

// ===== rtl/vsdc_vps_mem.sv
module vsdc_vps_mem (
   input  wire logic       clk_sys,  // system clock
   input  wire logic       we,       // write strobe
   input  wire logic [3:0] waddr,    // write column
   input  wire logic [7:0] wdata,    // write byte
   input  wire logic [3:0] raddr,    // read column
   output logic      [7:0] rdata_q   // registered read byte
);
   logic [7:0] mem [0:15];  // vps row storage

   // write port and registered read port
   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_q <= mem[raddr];
   end
endmodule

// ===== rtl/vsdc_top.sv
module vsdc_top (
   input  wire logic                    clk_sys,         // system clock, 40 MHz
   input  wire logic                    sys_rst,         // synchronous reset, active high
   // packet decoder side
   input  wire logic                    pkt_valid,       // one-cycle packet detected
   input  wire logic [4:0]              pkt_number,      // packet row number
   input  wire logic [2:0]              pkt_mag,         // magazine bits as received
   input  wire logic                    pkt_tab,         // tabulation bit, 525-line only
   input  wire logic [3:0]              pkt_desig,       // designation code
   // line timing side
   input  wire logic                    line_start,      // pulse at line start
   input  wire logic                    line_end,        // pulse at line end
   input  wire logic [8:0]              line_num,        // current line number
   input  wire logic                    field_odd,       // field id, 0 for field 0
   input  wire logic                    line_is_vps,     // slicer found vps on this line
   // vps slicer
   input  wire logic                    vps_valid,       // one-cycle vps byte
   input  wire logic [3:0]              vps_col,         // column of byte in row
   input  wire logic [3:0]              vps_bits,        // biphase decoded bits
   input  wire logic                    vps_err,         // biphase error
   // wide screen slicer
   input  wire logic                    wss_valid,       // one-cycle word complete
   input  wire logic [13:0]             wss_bits,        // 14 data bits
   input  wire logic [13:0]             wss_err,         // per-bit error
   // caption slicer
   input  wire logic                    cc_valid,        // one-cycle caption byte
   input  wire logic [7:0]              cc_byte,         // caption byte
   // axi4-lite slave
   input  wire logic [7:0]              s_axi_awaddr,    // write address
   input  wire logic                    s_axi_awvalid,   // write address valid
   output logic                         s_axi_awready,   // write address ready
   input  wire logic [31:0]             s_axi_wdata,     // write data
   input  wire logic [3:0]              s_axi_wstrb,     // byte enables
   input  wire logic                    s_axi_wvalid,    // write data valid
   output logic                         s_axi_wready,    // write data ready
   output logic [1:0]                   s_axi_bresp,     // write response
   output logic                         s_axi_bvalid,    // write response valid
   input  wire logic                    s_axi_bready,    // write response ready
   input  wire logic [7:0]              s_axi_araddr,    // read address
   input  wire logic                    s_axi_arvalid,   // read address valid
   output logic                         s_axi_arready,   // read address ready
   output logic [31:0]                  s_axi_rdata,     // read data
   output logic [1:0]                   s_axi_rresp,     // read response
   output logic                         s_axi_rvalid,    // read data valid
   input  wire logic                    s_axi_rready,    // read data ready
   output logic                         irq              // level interrupt
);
   import vsdc_pkg::*;

   // read channel states
   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,  // waiting for address
      RD_MEM  = 2'b01,  // memory read under way
      RD_RESP = 2'b10   // data offered
   } vsdc_rd_t;

   logic [12:0]       ctrl_q;        // control register
   logic [7:0]        wss_a_q;       // aspect group
   logic [7:0]        wss_b_q;       // enhanced services group
   logic [7:0]        wss_c_q;       // subtitle and reserved group
   logic [7:0]        cc_first_q;    // first caption byte
   logic [7:0]        cc_second_q;   // second caption byte
   logic [IRQ_W-1:0]  irq_mask_q;    // interrupt mask
   logic [FLAG_W-1:0] flags;         // detection flags
   logic [IRQ_W-1:0]  irq_stat;      // interrupt status

   // control fields
   wire        std525    = ctrl_q[CTRL_STD525_BIT];
   wire        vps_en    = ctrl_q[CTRL_VPS_EN_BIT];
   wire        wss_en    = ctrl_q[CTRL_WSS_EN_BIT];
   wire        cc_en     = ctrl_q[CTRL_CC_EN_BIT];
   wire        cc_irq_en = ctrl_q[CTRL_CC_IRQ_BIT];
   wire [4:0]  cc_line   = ctrl_q[CTRL_CCLINE_LSB+4:CTRL_CCLINE_LSB];

   // packet 27 code 0, acquired or not; 525-line needs tab bit clear
   wire link_hit = pkt_valid && (pkt_number == PKT_LINK)
                   && (pkt_desig == DESIG_ZERO)
                   && (!std525 || !pkt_tab);
   // magazine 8 codes as 000; 525-line has two bits, 00 is magazine 4
   wire mag_svc  = std525 ? (pkt_mag[1:0] == 2'b00)
                          : (pkt_mag == 3'b000);
   wire svc_hit  = pkt_valid && (pkt_number == PKT_SERVICE) && mag_svc;

   logic vps_got_q;  // a vps byte landed on this line
   wire  on_vps_line = (line_num == LINE_VPS) && !field_odd;
   // the slicer reports which format it found; only vps bytes reach memory
   wire  vps_take    = vps_en && on_vps_line && line_is_vps && vps_valid;
   // top data bit is never stored as one
   wire  vps_b3      = (vps_col == VPS_MSB_IDX) ? 1'b0 : vps_bits[3];
   wire [7:0] vps_word = {3'b000, vps_err, vps_b3, vps_bits[2:0]};
   wire  vps_done    = line_end && vps_got_q;

   // note that vps data arrived, closed at line end
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         vps_got_q <= 1'b0;
      end else if (line_end) begin
         vps_got_q <= 1'b0;
      end else if (vps_take) begin
         vps_got_q <= 1'b1;
      end
   end

   wire wss_take = wss_en && wss_valid && (line_num == LINE_WSS);

   // groups of related bits with one error flag each
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wss_a_q <= 8'h00;
         wss_b_q <= 8'h00;
         wss_c_q <= 8'h00;
      end else if (wss_take) begin
         wss_a_q <= {3'b000, |wss_err[3:0],  wss_bits[3:0]};
         wss_b_q <= {3'b000, |wss_err[7:4],  wss_bits[7:4]};
         wss_c_q <= {1'b0,   |wss_err[13:8], wss_bits[13:8]};
      end
   end

   logic cc_active_q;  // inside the selected caption line
   logic cc_cnt_q;     // second byte expected
   wire  cc_line_hit = (line_num == {4'h0, cc_line});
   wire  cc_open     = cc_en && line_start && cc_line_hit;
   wire  cc_close    = cc_active_q && line_end;
   wire  cc_take     = cc_active_q && cc_valid && cc_en;

   // caption line window and byte counter
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cc_active_q <= 1'b0;
         cc_cnt_q    <= 1'b0;
      end else if (cc_open) begin
         cc_active_q <= 1'b1;
         cc_cnt_q    <= 1'b0;
      end else if (cc_close) begin
         cc_active_q <= 1'b0;
      end else if (cc_take) begin
         cc_cnt_q    <= 1'b1;
      end
   end

   // caption data registers, cleared at the start of the line
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cc_first_q  <= 8'h00;
         cc_second_q <= 8'h00;
      end else if (cc_open) begin
         cc_first_q  <= 8'h00;
         cc_second_q <= 8'h00;
      end else if (cc_take && !cc_cnt_q) begin
         cc_first_q  <= cc_byte;
      end else if (cc_take) begin
         cc_second_q <= cc_byte;
      end
   end

   logic        aw_hold_q;   // write address held
   logic        w_hold_q;    // write data held
   logic [7:0]  awaddr_q;    // held write address
   logic [31:0] wdata_q;     // held write data
   logic [3:0]  wstrb_q;     // held byte enables
   logic        awready_q;   // address ready flop
   logic        wready_q;    // data ready flop
   logic        bvalid_q;    // response valid flop
   logic [1:0]  bresp_q;     // response code

   wire aw_take  = s_axi_awvalid && awready_q;
   wire w_take   = s_axi_wvalid && wready_q;
   wire aw_hold_d = (aw_hold_q || aw_take);
   wire w_hold_d  = (w_hold_q || w_take);
   wire do_write = aw_hold_q && w_hold_q && !bvalid_q;
   wire b_done   = bvalid_q && s_axi_bready;

   // write decode
   wire wr_ctrl  = do_write && (awaddr_q == OFS_CTRL);
   wire wr_flags = do_write && (awaddr_q == OFS_FLAGS) && wstrb_q[0];
   wire wr_istat = do_write && (awaddr_q == OFS_IRQ_STAT) && wstrb_q[0];
   wire wr_imask = do_write && (awaddr_q == OFS_IRQ_MASK) && wstrb_q[0];
   wire wr_ro    = (awaddr_q == OFS_WSS_A) || (awaddr_q == OFS_WSS_B)
                   || (awaddr_q == OFS_WSS_C) || (awaddr_q == OFS_CC_FIRST)
                   || (awaddr_q == OFS_CC_SECOND);
   wire wr_ok    = (awaddr_q == OFS_CTRL) || (awaddr_q == OFS_FLAGS)
                   || (awaddr_q == OFS_IRQ_STAT) || (awaddr_q == OFS_IRQ_MASK)
                   || wr_ro;
   // flags clear where a zero is written
   wire [FLAG_W-1:0] flag_clr = wr_flags ? ~wdata_q[FLAG_W-1:0] : '0;
   // interrupt status clears where a one is written
   wire [IRQ_W-1:0]  istat_clr = wr_istat ? wdata_q[IRQ_W-1:0] : '0;

   // address and data capture, in either order
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
      end else begin
         aw_hold_q <= aw_hold_d && !do_write;
         w_hold_q  <= w_hold_d && !do_write;
         if (aw_take) begin
            awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (w_take) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
      end
   end

   // ready and response flops
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         awready_q <= !(aw_hold_d && !do_write);
         wready_q  <= !(w_hold_d && !do_write);
         if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (b_done) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // control and mask registers with byte enables
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ctrl_q     <= {CC_LINE_RST, 8'h00};
         irq_mask_q <= '0;
      end else begin
         if (wr_ctrl && wstrb_q[0]) begin
            ctrl_q[7:0] <= {3'b000, wdata_q[4:0]};
         end
         if (wr_ctrl && wstrb_q[1]) begin
            ctrl_q[12:8] <= wdata_q[12:8];
         end
         if (wr_imask) begin
            irq_mask_q <= wdata_q[IRQ_W-1:0];
         end
      end
   end

   wire [FLAG_W-1:0] flag_set = {wss_take, vps_done, svc_hit, link_hit};
   wire cc_irq_ev = cc_close && cc_irq_en;
   wire [IRQ_W-1:0] istat_set = {wss_take, vps_done, cc_irq_ev};

   // detection flags, cleared by writing zero
   vsdc_sticky #(.W(FLAG_W)) u_flags (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .set_ev  (flag_set),
      .clr_ev  (flag_clr),
      .flag_q  (flags)
   );

   // interrupt status, cleared by writing one
   vsdc_sticky #(.W(IRQ_W)) u_istat (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .set_ev  (istat_set),
      .clr_ev  (istat_clr),
      .flag_q  (irq_stat)
   );

   logic irq_q;  // registered interrupt level
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irq_stat & irq_mask_q);
      end
   end

   logic [7:0] araddr_q;   // held read address
   logic [7:0] mem_rdata;  // memory read byte
   vsdc_vps_mem u_vps_mem (
      .clk_sys (clk_sys),
      .we      (vps_take),
      .waddr   (vps_col),
      .wdata   (vps_word),
      .raddr   (araddr_q[5:2]),
      .rdata_q (mem_rdata)
   );

   vsdc_rd_t    rd_q;        // read state
   logic        arready_q;   // address ready flop
   logic        rvalid_q;    // data valid flop
   logic [31:0] rdata_q;     // read data flop
   logic [1:0]  rresp_q;     // read response

   wire ar_take = s_axi_arvalid && arready_q;
   wire r_done  = rvalid_q && s_axi_rready;
   wire rd_vps  = (araddr_q[7:6] == OFS_VPS_BASE[7:6]);  // row window only, no alias above
   // register read select
   wire [31:0] reg_rd =
      (araddr_q == OFS_CTRL)      ? {19'h0, ctrl_q} :
      (araddr_q == OFS_FLAGS)     ? {28'h0, flags} :
      (araddr_q == OFS_WSS_A)     ? {24'h0, wss_a_q} :
      (araddr_q == OFS_WSS_B)     ? {24'h0, wss_b_q} :
      (araddr_q == OFS_WSS_C)     ? {24'h0, wss_c_q} :
      (araddr_q == OFS_CC_FIRST)  ? {24'h0, cc_first_q} :
      (araddr_q == OFS_CC_SECOND) ? {24'h0, cc_second_q} :
      (araddr_q == OFS_IRQ_STAT)  ? {29'h0, irq_stat} :
      (araddr_q == OFS_IRQ_MASK)  ? {29'h0, irq_mask_q} : 32'h0000_0000;
   wire rd_ok = rd_vps || (araddr_q <= OFS_IRQ_MASK);

   // read sequencer: address, one memory cycle, answer
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rd_q      <= RD_IDLE;
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         araddr_q  <= 8'h00;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= RESP_OKAY;
      end else begin
         case (rd_q)
            RD_IDLE: begin
               arready_q <= !ar_take;
               if (ar_take) begin
                  araddr_q <= {s_axi_araddr[7:2], 2'b00};
                  rd_q     <= RD_MEM;
               end
            end
            RD_MEM: begin
               rd_q <= RD_RESP;
            end
            RD_RESP: begin
               // answer once memory data has settled
               if (!rvalid_q) begin
                  rvalid_q <= 1'b1;
                  rdata_q  <= rd_vps ? {24'h0, mem_rdata} : reg_rd;
                  rresp_q  <= (rd_ok && araddr_q[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
               end else if (r_done) begin
                  rvalid_q  <= 1'b0;
                  arready_q <= 1'b1;
                  rd_q      <= RD_IDLE;
               end
            end
            default: begin
               rd_q <= RD_IDLE;
            end
         endcase
      end
   end

   // outputs straight from flops
   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign irq           = irq_q;
endmodule

// ===== verification/vsdc_monitor.sv
module vsdc_monitor (
   input wire logic        clk_sys,       // clock
   input wire logic        sys_rst,       // reset
   input wire logic        line_end,      // line end
   input wire logic        wss_valid,     // wss word
   input wire logic        s_axi_awvalid, // aw valid
   input wire logic        s_axi_awready, // aw ready
   input wire logic        s_axi_wvalid,  // w valid
   input wire logic        s_axi_wready,  // w ready
   input wire logic [1:0]  s_axi_bresp,   // b resp
   input wire logic        s_axi_bvalid,  // b valid
   input wire logic        s_axi_bready,  // b ready
   input wire logic        s_axi_arvalid, // ar valid
   input wire logic        s_axi_arready, // ar ready
   input wire logic [31:0] s_axi_rdata,   // r data
   input wire logic        s_axi_rvalid,  // r valid
   input wire logic        s_axi_rready,  // r ready
   input wire logic        irq            // interrupt
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // a reset edge leaves responses idle and the interrupt low
   chk_reset_quiet: assert property (disable iff (1'h0) sys_rst |=> !s_axi_bvalid && !irq
      && !s_axi_rvalid && s_axi_bresp == 2'h0) else $error("busy after reset");
   // responses hold while the master stalls
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped");
   // answers come within the promised latency
   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[2:3] s_axi_rvalid)
      else $error("read answer late");
   // ready drops after each transfer; no read address taken while read data is pending
   chk_aw_busy: assert property ((s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      and (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)) else $error("write taken twice");
   chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read ready during response");
   chk_irq_cause: assert property ($rose(irq) |-> $past(line_end, 2) || $past(wss_valid, 2)
      || s_axi_bvalid || $past(s_axi_bvalid)) else $error("interrupt without cause");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (s_axi_rvalid && s_axi_rready);
   cover property ($rose(irq));
endmodule

// ===== verification/vsdc_slicer_model.sv
module vsdc_slicer_model (
   input  wire logic   clk_sys,     // clock
   output logic        pkt_valid,   // packet
   output logic [4:0]  pkt_number,  // row
   output logic [2:0]  pkt_mag,     // magazine
   output logic        pkt_tab,     // tab bit
   output logic [3:0]  pkt_desig,   // designation
   output logic        line_start,  // line start
   output logic        line_end,    // line end
   output logic [8:0]  line_num,    // line
   output logic        field_odd,   // field
   output logic        line_is_vps, // vps line
   output logic        vps_valid,   // vps byte
   output logic [3:0]  vps_col,     // column
   output logic [3:0]  vps_bits,    // vps data
   output logic        vps_err,     // vps error
   output logic        wss_valid,   // wss word
   output logic [13:0] wss_bits,    // wss data
   output logic [13:0] wss_err,     // wss errors
   output logic        cc_valid,    // caption
   output logic [7:0]  cc_byte      // caption byte
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {pkt_valid, pkt_number, pkt_mag, pkt_tab, pkt_desig, line_start, line_end, line_num,
      field_odd, line_is_vps, vps_valid, vps_col, vps_bits, vps_err, wss_valid, wss_bits,
      wss_err, cc_valid, cc_byte} = '0;
   // end a pulse and invert released data so stale values show
   task automatic gap;
      @(posedge clk_sys);
      {pkt_valid, line_start, line_end, vps_valid, wss_valid, cc_valid} <= '0;
      {pkt_desig, vps_bits, wss_bits, cc_byte} <= ~{pkt_desig, vps_bits, wss_bits, cc_byte};
   endtask
   task automatic pk(input logic [4:0] n, input logic [2:0] m, input logic t);
      @(posedge clk_sys);
      {pkt_valid, pkt_number, pkt_mag, pkt_tab, pkt_desig} <= {1'h1, n, m, t, 4'h0};
      gap();
   endtask
   task automatic ln(input logic [8:0] n, input logic f, input logic v);
      @(posedge clk_sys);
      {line_start, line_num, field_odd, line_is_vps} <= {1'h1, n, f, v};
      gap();
   endtask
   task automatic le;
      @(posedge clk_sys);
      line_end <= 1'h1;
      gap();
   endtask
   task automatic vp(input logic [3:0] c, input logic [3:0] b, input logic e);
      @(posedge clk_sys);
      {vps_valid, vps_col, vps_bits, vps_err} <= {1'h1, c, b, e};
      gap();
   endtask
   task automatic ws(input logic [13:0] b, input logic [13:0] e);
      @(posedge clk_sys);
      {wss_valid, wss_bits, wss_err} <= {1'h1, b, e};
      gap();
   endtask
   task automatic cc(input logic [7:0] b);
      @(posedge clk_sys);
      {cc_valid, cc_byte} <= {1'h1, b};
      gap();
   endtask
endmodule

// ===== verification/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import vsdc_pkg::*;
   logic        clk_sys = 1'h0, sys_rst = 1'h1;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, cc_byte;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF, pkt_desig, vps_col, vps_bits;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        pkt_valid, pkt_tab, line_start, line_end, field_odd, line_is_vps;
   logic        vps_valid, vps_err, wss_valid, cc_valid;
   logic [4:0]  pkt_number;
   logic [2:0]  pkt_mag;
   logic [8:0]  line_num;
   logic [13:0] wss_bits, wss_err;
   int          failures = 0, checks_done = 0;
   vsdc_top uut (.*);
   vsdc_slicer_model sl (.*);
   always #12.5 clk_sys = ~clk_sys;
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   // write: address, data and ready offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge clk_sys);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      chk("bresp", 32'h0 | r, 32'h0 | s_axi_bresp);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge clk_sys);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", 32'h0 | r, 32'h0 | s_axi_rresp);
   endtask
   task automatic results;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #300us;
      failures++;
      results();
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'h0;
      rd(OFS_CTRL, 32'h1500, RESP_OKAY);
      rd(8'h30, 32'h0, RESP_SLVERR);
      sl.pk(PKT_LINK, 3'h1, 1'h0);
      sl.pk(PKT_SERVICE, 3'h0, 1'h0);
      rd(OFS_FLAGS, 32'h3, RESP_OKAY);
      wr(OFS_FLAGS, 32'h0, RESP_OKAY);
      rd(OFS_FLAGS, 32'h0, RESP_OKAY);
      wr(OFS_CTRL, 32'h1501, RESP_OKAY);
      sl.pk(PKT_LINK, 3'h4, 1'h1);
      sl.pk(PKT_SERVICE, 3'h1, 1'h0);
      rd(OFS_FLAGS, 32'h0, RESP_OKAY);
      sl.pk(PKT_LINK, 3'h4, 1'h0);
      sl.pk(PKT_SERVICE, 3'h4, 1'h0);
      rd(OFS_FLAGS, 32'h3, RESP_OKAY);
      $display("test packet flags finished");
      wr(OFS_FLAGS, 32'h0, RESP_OKAY);
      wr(OFS_CTRL, 32'h1500, RESP_OKAY);
      sl.ln(LINE_WSS, 1'h0, 1'h0);
      sl.ws(14'h2A5C, 14'h0010);
      rd(OFS_FLAGS, 32'h0, RESP_OKAY);
      wr(OFS_CTRL, 32'h1504, RESP_OKAY);
      sl.ws(14'h2A5C, 14'h0010);
      rd(OFS_FLAGS, 32'h8, RESP_OKAY);
      rd(OFS_WSS_A, 32'h0C, RESP_OKAY);
      rd(OFS_WSS_B, 32'h15, RESP_OKAY);
      rd(OFS_WSS_C, 32'h2A, RESP_OKAY);
      $display("test wide screen finished");
      wr(OFS_FLAGS, 32'h0, RESP_OKAY);
      wr(OFS_CTRL, 32'h1502, RESP_OKAY);
      sl.ln(LINE_VPS, 1'h1, 1'h1);
      sl.vp(4'h2, 4'h3, 1'h0);
      sl.le();
      sl.ln(LINE_VPS, 1'h0, 1'h0);
      sl.vp(4'h1, 4'h3, 1'h0);
      sl.le();
      rd(OFS_FLAGS, 32'h0, RESP_OKAY);
      sl.ln(LINE_VPS, 1'h0, 1'h1);
      sl.vp(4'h0, 4'hF, 1'h0);
      sl.vp(4'h5, 4'hA, 1'h1);
      sl.le();
      rd(OFS_FLAGS, 32'h4, RESP_OKAY);
      rd(OFS_VPS_BASE, 32'h07, RESP_OKAY);
      rd(OFS_VPS_BASE + 8'h14, 32'h1A, RESP_OKAY);
      $display("test vps finished");
      wr(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
      wr(OFS_CTRL, 32'h1518, RESP_OKAY);
      sl.ln(9'h015, 1'h0, 1'h0);
      sl.cc(8'h41);
      sl.cc(8'h42);
      sl.le();
      repeat (3) @(posedge clk_sys);
      chk("irq", 32'h1, 32'h0 | irq);
      rd(OFS_CC_FIRST, 32'h41, RESP_OKAY);
      rd(OFS_CC_SECOND, 32'h42, RESP_OKAY);
      wr(OFS_IRQ_STAT, 32'h7, RESP_OKAY);
      repeat (3) @(posedge clk_sys);
      chk("irq", 32'h0, 32'h0 | irq);
      sl.ln(9'h015, 1'h1, 1'h0);
      rd(OFS_CC_SECOND, 32'h0, RESP_OKAY);
      wr(OFS_CTRL, 32'h1510, RESP_OKAY);
      sl.cc(8'h55);
      rd(OFS_CC_FIRST, 32'h0, RESP_OKAY);
      $display("test caption finished");
      results();
   end
endmodule
bind vsdc_top vsdc_monitor mon (.*);
